// ---- hw/sss_cfg.svh ----
// status codes, display patterns and timing constants of the servo status sequencer
`ifndef SSS_CFG_SVH
`define SSS_CFG_SVH
`define SSS_CODE_PWR_OFF    5'h00
`define SSS_CODE_PWR_ON     5'h02
`define SSS_CODE_SRV_RDY    5'h04
`define SSS_CODE_SRV_ON     5'h08
`define SSS_CODE_EST_RDY    5'h09
`define SSS_CODE_EMR        5'h0a
`define SSS_CODE_INIT       5'h0f
`define SSS_DISP_NORMAL     3'h0
`define SSS_DISP_BLINK      3'h1
`define SSS_DISP_ROTATE     3'h2
`define SSS_DISP_FWD_OT     3'h3
`define SSS_DISP_REV_OT     3'h4
`define SSS_DISP_WARN_REGEN 3'h5
`define SSS_DISP_WARN_OVL   3'h6
`define SSS_DISP_ALARM      3'h7
`define SSS_MON_STATUS      8'h00
`define SSS_EST_LIMIT_DEG   8'h12
`define SSS_RST_TIME_MS     20
`define SSS_CLK_KHZ         50000
`define SSS_RST_CYCLES      (`SSS_RST_TIME_MS * `SSS_CLK_KHZ)
`define SSS_EST_STEP_DEG    8'h01
`define SSS_RATIO_SCALE     16'h0064
`define SSS_TUNE_JRAT_FIX   2'h1
`endif

// ---- hw/sss_pkg.sv ----
// state types of the driver end and of the host end of the servo status sequencer
package sss_pkg;
   typedef enum logic [5:0] {
      SSS_POWER   = 6'b000001,
      SSS_MAINPWR = 6'b000010,
      SSS_ESTRDY  = 6'b000100,
      SSS_ESTRUN  = 6'b001000,
      SSS_READY   = 6'b010000,
      SSS_SERVOON = 6'b100000
   } sss_state_t;
   typedef enum logic [3:0] {
      SSS_H_IDLE  = 4'b0001,
      SSS_H_EST   = 4'b0010,
      SSS_H_RUN   = 4'b0100,
      SSS_H_ARST  = 4'b1000
   } sss_host_state_t;
endpackage

// ---- hw/sss_link_if.sv ----
// general-purpose signals between host controller and driver
`timescale 1ns/1ns
interface sss_link_if;
   logic servo_on_in;
   logic general_input_three;
   logic alarm_reset_in;
   logic forward_travel_limit;
   logic reverse_travel_limit;
   logic driver_ready_out;
   logic estimation_ready_out;
   logic setup_done_out;
   logic cmd_enable_out;
   logic alarm_out;
   logic warning_out;
   modport drv (
      input  servo_on_in, general_input_three, alarm_reset_in,
      input  forward_travel_limit, reverse_travel_limit,
      output driver_ready_out, estimation_ready_out, setup_done_out,
      output cmd_enable_out, alarm_out, warning_out
   );
   modport host (
      output servo_on_in, general_input_three, alarm_reset_in,
      output forward_travel_limit, reverse_travel_limit,
      input  driver_ready_out, estimation_ready_out, setup_done_out,
      input  cmd_enable_out, alarm_out, warning_out
   );
endinterface

// ---- hw/sss_driver.sv ----
// driver end: status sequencing, display code, alarm stop and reset
// How it works
// - control power with ready reports code 0
// - main power, setup not done reports 2
// - estimation ready reports 9, display blinks
// - estimation done sets setup output, code 4
// - servo on reports 8, rotating display
// - servo-on input energises windings
// - host starts estimation via third input
// - estimation excursion limited to eighteen degrees
// - host selects fixed-inertia tuning, writes ratio
// - distinct display per over-travel direction
// - regen and overload warnings, may escalate
// - alarm shows alarm code with status
// - alarm stops by dynamic or servo brake
// - alarm reset clears resettable, gone alarms
// - some alarms clear only on power cycle
// - host drops reset after alarm clears
// - unmonitored host holds reset 20 ms
// - host commands only after enable output
// - status code readable as monitor 00
`timescale 1ns/1ns
`include "sss_cfg.svh"
module sss_driver #(
   parameter int ALARM_W = 8
) (
   // clock and reset (srst models control power restart)
   input  wire logic               clk,
   input  wire logic               srst,
   // link to host
   sss_link_if.drv                 link,
   // power and plant status
   input  wire logic               main_power,
   input  wire logic               emergency_stop_state,
   input  wire logic               est_step_done,
   input  wire logic               regen_warn_in,
   input  wire logic               overload_warn_in,
   // alarm source: level, code, kind
   input  wire logic               alarm_cond,
   input  wire logic [ALARM_W-1:0] alarm_code_in,
   input  wire logic               alarm_resettable,
   input  wire logic               alarm_use_dbrake,
   // monitor read
   input  wire logic [7:0]         monitor_id,
   output logic [7:0]              monitor_data,
   // motor drive
   output logic                    windings_on,
   output logic                    dyn_brake,
   output logic                    zero_speed_cmd,
   output logic signed [7:0]       est_angle_deg,
   // front display
   output logic [4:0]              status_code,
   output logic [2:0]              disp_mode,
   output logic [ALARM_W-1:0]      disp_alarm_code
);
   ////////////////////////////////////////////////////////////////////////
   // pin synchronisers
   logic [6:0] sy1_ff;
   logic [6:0] sy2_ff;
   logic [6:0] nxt_sy1;
   logic [6:0] nxt_sy2;
   logic       s_son;
   logic       s_est;
   logic       s_arst;
   logic       s_fot;
   logic       s_rot;
   logic       s_mpwr;
   logic       s_emr;
   always_comb begin
      nxt_sy1 = {emergency_stop_state, main_power, link.reverse_travel_limit,
                 link.forward_travel_limit, link.alarm_reset_in,
                 link.general_input_three, link.servo_on_in};
      nxt_sy2 = sy1_ff;
   end
   always_ff @(posedge clk) begin
      if (srst) begin
         sy1_ff <= 7'h00;
         sy2_ff <= 7'h00;
      end else begin
         sy1_ff <= nxt_sy1;
         sy2_ff <= nxt_sy2;
      end
   end
   assign {s_emr, s_mpwr, s_rot, s_fot, s_arst, s_est, s_son} = sy2_ff;
   ////////////////////////////////////////////////////////////////////////
   // sequencer
   sss_pkg::sss_state_t       st_ff;
   sss_pkg::sss_state_t       nxt_st;
   logic                      est_done_ff;
   logic                      nxt_est_done;
   logic signed [7:0]         ang_ff;
   logic signed [7:0]         nxt_ang;
   logic                      dir_ff;
   logic                      nxt_dir;
   logic                      alm_ff;
   logic                      nxt_alm;
   logic                      alm_hard_ff;
   logic                      nxt_alm_hard;
   logic                      alm_db_ff;
   logic                      nxt_alm_db;
   logic [ALARM_W-1:0]        alm_code_ff;
   logic [ALARM_W-1:0]        nxt_alm_code;
   logic signed [7:0]         lim;
   assign lim = `SSS_EST_LIMIT_DEG;
   always_comb begin
      nxt_st       = st_ff;
      nxt_est_done = est_done_ff;
      nxt_ang      = ang_ff;
      nxt_dir      = dir_ff;
      nxt_alm      = alm_ff;
      nxt_alm_hard = alm_hard_ff;
      nxt_alm_db   = alm_db_ff;
      nxt_alm_code = alm_code_ff;
      // alarm latch; a new alarm wins over a reset
      if (alarm_cond && !alm_ff) begin
         nxt_alm      = 1'b1;
         nxt_alm_hard = !alarm_resettable;
         nxt_alm_db   = alarm_use_dbrake;
         nxt_alm_code = alarm_code_in;
      end else if (alm_ff && s_arst && !alarm_cond && !alm_hard_ff) begin
         nxt_alm = 1'b0;
      end
      case (st_ff)
         sss_pkg::SSS_POWER: begin
            if (s_mpwr) begin
               nxt_st = est_done_ff ? sss_pkg::SSS_READY : sss_pkg::SSS_MAINPWR;
            end
         end
         sss_pkg::SSS_MAINPWR: begin
            if (!est_done_ff) begin
               nxt_st = sss_pkg::SSS_ESTRDY;
            end
         end
         sss_pkg::SSS_ESTRDY: begin
            if (s_est && !alm_ff) begin
               nxt_st  = sss_pkg::SSS_ESTRUN;
               nxt_ang = 8'sh00;
               nxt_dir = 1'b0;
            end
         end
         sss_pkg::SSS_ESTRUN: begin
            if (alm_ff) begin
               nxt_st  = sss_pkg::SSS_ESTRDY;
               nxt_ang = 8'sh00;
            end else if (est_step_done) begin
               if (!dir_ff && ang_ff < lim) begin
                  nxt_ang = ang_ff + `SSS_EST_STEP_DEG;
               end else if (!dir_ff) begin
                  nxt_dir = 1'b1;
               end else if (ang_ff > -lim) begin
                  nxt_ang = ang_ff - `SSS_EST_STEP_DEG;
               end else begin
                  nxt_st       = sss_pkg::SSS_READY;
                  nxt_est_done = 1'b1;
                  nxt_ang      = 8'sh00;
               end
            end
         end
         sss_pkg::SSS_READY: begin
            if (s_son && est_done_ff && !alm_ff && !s_emr) begin
               nxt_st = sss_pkg::SSS_SERVOON;
            end
         end
         sss_pkg::SSS_SERVOON: begin
            if (!s_son || alm_ff || s_emr) begin
               nxt_st = sss_pkg::SSS_READY;
            end
         end
         default: nxt_st = sss_pkg::SSS_POWER;
      endcase
      if (!s_mpwr) begin
         nxt_st = sss_pkg::SSS_POWER;
      end
   end
   always_ff @(posedge clk) begin
      if (srst) begin
         st_ff       <= sss_pkg::SSS_POWER;
         est_done_ff <= 1'b0;
         ang_ff      <= 8'sh00;
         dir_ff      <= 1'b0;
         alm_ff      <= 1'b0;
         alm_hard_ff <= 1'b0;
         alm_db_ff   <= 1'b0;
         alm_code_ff <= '0;
      end else begin
         st_ff       <= nxt_st;
         est_done_ff <= nxt_est_done;
         ang_ff      <= nxt_ang;
         dir_ff      <= nxt_dir;
         alm_ff      <= nxt_alm;
         alm_hard_ff <= nxt_alm_hard;
         alm_db_ff   <= nxt_alm_db;
         alm_code_ff <= nxt_alm_code;
      end
   end
   ////////////////////////////////////////////////////////////////////////
   // outputs and display
   logic [4:0]         nxt_code;
   logic [2:0]         nxt_disp;
   logic [7:0]         nxt_mon;
   logic               nxt_win;
   logic               nxt_db;
   logic               nxt_zs;
   logic [5:0]         nxt_pins;
   logic [5:0]         pins_ff;
   always_comb begin
      nxt_code = `SSS_CODE_PWR_OFF;
      case (st_ff)
         sss_pkg::SSS_POWER:   nxt_code = `SSS_CODE_PWR_OFF;
         sss_pkg::SSS_MAINPWR: nxt_code = `SSS_CODE_PWR_ON;
         sss_pkg::SSS_ESTRDY:  nxt_code = `SSS_CODE_EST_RDY;
         sss_pkg::SSS_ESTRUN:  nxt_code = `SSS_CODE_EST_RDY;
         sss_pkg::SSS_READY:   nxt_code = `SSS_CODE_SRV_RDY;
         sss_pkg::SSS_SERVOON: nxt_code = `SSS_CODE_SRV_ON;
         default:              nxt_code = `SSS_CODE_INIT;
      endcase
      if (s_emr) begin
         nxt_code = `SSS_CODE_EMR;
      end
      nxt_disp = `SSS_DISP_NORMAL;
      if (st_ff == sss_pkg::SSS_ESTRDY) begin
         nxt_disp = `SSS_DISP_BLINK;
      end else if (st_ff == sss_pkg::SSS_ESTRUN || st_ff == sss_pkg::SSS_SERVOON) begin
         nxt_disp = `SSS_DISP_ROTATE;
      end
      if (regen_warn_in) begin
         nxt_disp = `SSS_DISP_WARN_REGEN;
      end else if (overload_warn_in) begin
         nxt_disp = `SSS_DISP_WARN_OVL;
      end
      if (s_fot) begin
         nxt_disp = `SSS_DISP_FWD_OT;
      end else if (s_rot) begin
         nxt_disp = `SSS_DISP_REV_OT;
      end
      if (alm_ff) begin
         nxt_disp = `SSS_DISP_ALARM;
      end
      nxt_mon  = (monitor_id == `SSS_MON_STATUS) ? {3'h0, nxt_code} : 8'h00;
      nxt_win  = (nxt_st == sss_pkg::SSS_SERVOON) || (nxt_st == sss_pkg::SSS_ESTRUN);
      nxt_db   = nxt_alm && nxt_alm_db;
      nxt_zs   = nxt_alm && !nxt_alm_db;
      if (nxt_db) begin
         nxt_win = 1'b0;
      end
      nxt_pins = {regen_warn_in | overload_warn_in, nxt_alm,
                  (nxt_st == sss_pkg::SSS_SERVOON) && !nxt_alm,
                  nxt_est_done, nxt_st == sss_pkg::SSS_ESTRDY, !nxt_alm};
   end
   always_ff @(posedge clk) begin
      if (srst) begin
         status_code     <= `SSS_CODE_INIT;
         disp_mode       <= `SSS_DISP_NORMAL;
         disp_alarm_code <= '0;
         monitor_data    <= 8'h00;
         windings_on     <= 1'b0;
         dyn_brake       <= 1'b0;
         zero_speed_cmd  <= 1'b0;
         est_angle_deg   <= 8'sh00;
         pins_ff         <= 6'h00;
      end else begin
         status_code     <= nxt_code;
         disp_mode       <= nxt_disp;
         disp_alarm_code <= alm_ff ? alm_code_ff : '0;
         monitor_data    <= nxt_mon;
         windings_on     <= nxt_win;
         dyn_brake       <= nxt_db;
         zero_speed_cmd  <= nxt_zs;
         est_angle_deg   <= nxt_ang;
         pins_ff         <= nxt_pins;
      end
   end
   assign {link.warning_out, link.alarm_out, link.cmd_enable_out, link.setup_done_out,
           link.estimation_ready_out, link.driver_ready_out} = pins_ff;
endmodule

// ---- hw/sss_host.sv ----
// host end: estimation start, servo-on and alarm-reset handshake
`timescale 1ns/1ns
`include "sss_cfg.svh"
module sss_host #(
   parameter int RST_CYCLES = `SSS_RST_CYCLES
) (
   // clock and reset
   input  wire logic        clk,
   input  wire logic        srst,
   // link to driver
   sss_link_if.host         link,
   // user side
   input  wire logic        run_req,
   input  wire logic        alarm_reset_req,
   input  wire logic        monitor_alarm,
   input  wire logic        fwd_limit_in,
   input  wire logic        rev_limit_in,
   output logic             cmd_allowed,
   output logic             reset_timeout,
   output logic [1:0]       tuning_select,
   output logic [15:0]      load_inertia_ratio,
   // plant inertias for the ratio
   input  wire logic [15:0] load_inertia,
   input  wire logic [15:0] rotor_inertia
);
   ////////////////////////////////////////////////////////////////////////
   // pin synchronisers
   logic [4:0] sy1_ff;
   logic [4:0] sy2_ff;
   logic       s_rdy;
   logic       s_estrdy;
   logic       s_done;
   logic       s_cmd;
   logic       s_alm;
   always_ff @(posedge clk) begin
      if (srst) begin
         sy1_ff <= 5'h00;
         sy2_ff <= 5'h00;
      end else begin
         sy1_ff <= {link.alarm_out, link.cmd_enable_out, link.setup_done_out,
                    link.estimation_ready_out, link.driver_ready_out};
         sy2_ff <= sy1_ff;
      end
   end
   assign {s_alm, s_cmd, s_done, s_estrdy, s_rdy} = sy2_ff;
   ////////////////////////////////////////////////////////////////////////
   // sequencer
   sss_pkg::sss_host_state_t st_ff;
   sss_pkg::sss_host_state_t nxt_st;
   logic [31:0]              cnt_ff;
   logic [31:0]              nxt_cnt;
   logic                     to_ff;
   logic                     nxt_to;
   logic [31:0]              ratio;
   always_comb begin
      nxt_st  = st_ff;
      nxt_cnt = cnt_ff;
      nxt_to  = to_ff;
      case (st_ff)
         sss_pkg::SSS_H_IDLE: begin
            if (s_alm && alarm_reset_req) begin
               nxt_st  = sss_pkg::SSS_H_ARST;
               nxt_cnt = 32'h0;
               nxt_to  = 1'b0;
            end else if (run_req && s_estrdy && !s_alm) begin
               nxt_st = sss_pkg::SSS_H_EST;
            end else if (run_req && s_done && !s_alm) begin
               nxt_st = sss_pkg::SSS_H_RUN;
            end
         end
         sss_pkg::SSS_H_EST: begin
            if (s_done || !run_req || s_alm) begin
               nxt_st = sss_pkg::SSS_H_IDLE;
            end
         end
         sss_pkg::SSS_H_RUN: begin
            if (!run_req || s_alm) begin
               nxt_st = sss_pkg::SSS_H_IDLE;
            end
         end
         sss_pkg::SSS_H_ARST: begin
            if (cnt_ff < RST_CYCLES) begin
               nxt_cnt = cnt_ff + 32'h1;
            end
            if (monitor_alarm && !s_alm) begin
               nxt_st = sss_pkg::SSS_H_IDLE;
            end else if (cnt_ff >= RST_CYCLES) begin
               nxt_st = sss_pkg::SSS_H_IDLE;
               nxt_to = monitor_alarm && s_alm;
            end
         end
         default: nxt_st = sss_pkg::SSS_H_IDLE;
      endcase
   end
   always_ff @(posedge clk) begin
      if (srst) begin
         st_ff  <= sss_pkg::SSS_H_IDLE;
         cnt_ff <= 32'h0;
         to_ff  <= 1'b0;
      end else begin
         st_ff  <= nxt_st;
         cnt_ff <= nxt_cnt;
         to_ff  <= nxt_to;
      end
   end
   ////////////////////////////////////////////////////////////////////////
   // outputs
   assign ratio = (rotor_inertia == 16'h0) ? 32'h0 :
                  ({16'h0, load_inertia} * {16'h0, `SSS_RATIO_SCALE}) / {16'h0, rotor_inertia};
   always_ff @(posedge clk) begin
      if (srst) begin
         tuning_select      <= `SSS_TUNE_JRAT_FIX;
         load_inertia_ratio <= 16'h0;
         cmd_allowed        <= 1'b0;
         link.servo_on_in          <= 1'b0;
         link.general_input_three  <= 1'b0;
         link.alarm_reset_in       <= 1'b0;
         link.forward_travel_limit <= 1'b0;
         link.reverse_travel_limit <= 1'b0;
      end else begin
         tuning_select      <= `SSS_TUNE_JRAT_FIX;
         load_inertia_ratio <= ratio[15:0];
         cmd_allowed        <= (st_ff == sss_pkg::SSS_H_RUN) && s_cmd;
         link.servo_on_in          <= (st_ff == sss_pkg::SSS_H_RUN);
         link.general_input_three  <= (st_ff == sss_pkg::SSS_H_EST);
         link.alarm_reset_in       <= (st_ff == sss_pkg::SSS_H_ARST);
         link.forward_travel_limit <= fwd_limit_in;
         link.reverse_travel_limit <= rev_limit_in;
      end
   end
   assign reset_timeout = to_ff;
endmodule

// ---- dv/sss_properties.sv ----
// link checker of the servo status sequencer
`timescale 1ns/1ns
module sss_properties #(
   parameter int RST_CYCLES = 50
) (
   // clock and reset
   input wire logic clk,
   input wire logic srst,
   // link signals
   input wire logic servo_on_in,
   input wire logic general_input_three,
   input wire logic alarm_reset_in,
   input wire logic driver_ready_out,
   input wire logic estimation_ready_out,
   input wire logic setup_done_out,
   input wire logic cmd_enable_out,
   input wire logic alarm_out
);
   logic [31:0] hold_cnt_ff;
   logic [31:0] nxt_hold_cnt;
   ////////////////////////////////////////
   // length of the current alarm-reset request
   always_comb begin
      nxt_hold_cnt = alarm_reset_in ? hold_cnt_ff + 32'h1 : 32'h0;
      if (srst) begin
         nxt_hold_cnt = 32'h0;
      end
   end
   always_ff @(posedge clk) begin
      hold_cnt_ff <= nxt_hold_cnt;
   end
   ////////////////////////////////////////
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (srst);
   sequence s_servo_held;
      $past(servo_on_in) && $past(servo_on_in, 2);
   endsequence
   sequence s_reset_held;
      $past(alarm_reset_in) && $past(alarm_reset_in, 2);
   endsequence
   property p_ready_alarm;
      alarm_out |-> !driver_ready_out;
   endproperty
   a_ready_alarm: assert property (p_ready_alarm) else $error("ready with alarm");
   property p_enable_setup;
      cmd_enable_out |-> setup_done_out;
   endproperty
   a_enable_setup: assert property (p_enable_setup) else $error("on before setup");
   property p_enable_ready;
      cmd_enable_out |-> driver_ready_out && !alarm_out;
   endproperty
   a_enable_ready: assert property (p_enable_ready) else $error("on with alarm");
   property p_wait_not_done;
      estimation_ready_out |-> !setup_done_out;
   endproperty
   a_wait_not_done: assert property (p_wait_not_done) else $error("ready and done");
   property p_servo_cause;
      $rose(cmd_enable_out) |-> s_servo_held;
   endproperty
   a_servo_cause: assert property (p_servo_cause) else $error("on without request");
   property p_clear_cause;
      $fell(alarm_out) |-> s_reset_held;
   endproperty
   a_clear_cause: assert property (p_clear_cause) else $error("clear without reset");
   property p_release;
      $fell(alarm_reset_in) |-> !$past(alarm_out) || hold_cnt_ff >= RST_CYCLES - 1;
   endproperty
   a_release: assert property (p_release) else $error("reset dropped early");
   property p_est_order;
      $rose(general_input_three) |-> $past(estimation_ready_out);
   endproperty
   a_est_order: assert property (p_est_order) else $error("start out of order");
endmodule

// ---- dv/servo_status_sequencer_test.sv ----
// bench joining host and driver ends of the servo status sequencer
`timescale 1ns/1ns
`include "sss_cfg.svh"
module servo_status_sequencer_test;
   localparam int RC = 50;
   logic              clk, srst, windings_on, dyn_brake, zero_speed_cmd, cmd_allowed;
   logic              main_power, emergency_stop_state, est_step_done, regen_warn_in;
   logic              overload_warn_in, alarm_cond, alarm_resettable, alarm_use_dbrake;
   logic              run_req, alarm_reset_req, monitor_alarm, fwd_limit_in, rev_limit_in;
   logic              reset_timeout;
   logic [7:0]        alarm_code_in, monitor_id, monitor_data, disp_alarm_code;
   logic signed [7:0] est_angle_deg, hi, lo;
   logic [4:0]        status_code;
   logic [2:0]        disp_mode;
   logic [1:0]        tuning_select;
   logic [15:0]       load_inertia, rotor_inertia, load_inertia_ratio;
   int                num_errors = 0, samples_checked = 0, cycles = 0;
   ////////////////////////////////////////
   sss_link_if sss_link_if_i ();
   sss_driver sss_driver_i (.clk, .srst, .link(sss_link_if_i), .main_power,
      .emergency_stop_state, .est_step_done, .regen_warn_in, .overload_warn_in, .alarm_cond,
      .alarm_code_in, .alarm_resettable, .alarm_use_dbrake, .monitor_id, .monitor_data,
      .windings_on, .dyn_brake, .zero_speed_cmd, .est_angle_deg, .status_code, .disp_mode,
      .disp_alarm_code);
   sss_host #(.RST_CYCLES(RC)) sss_host_i (.clk, .srst, .link(sss_link_if_i), .run_req,
      .alarm_reset_req, .monitor_alarm, .fwd_limit_in, .rev_limit_in, .cmd_allowed,
      .reset_timeout, .tuning_select, .load_inertia_ratio, .load_inertia, .rotor_inertia);
   sss_properties #(.RST_CYCLES(RC)) sss_properties_i (.clk, .srst,
      .servo_on_in(sss_link_if_i.servo_on_in),
      .general_input_three(sss_link_if_i.general_input_three),
      .alarm_reset_in(sss_link_if_i.alarm_reset_in),
      .driver_ready_out(sss_link_if_i.driver_ready_out),
      .estimation_ready_out(sss_link_if_i.estimation_ready_out),
      .setup_done_out(sss_link_if_i.setup_done_out),
      .cmd_enable_out(sss_link_if_i.cmd_enable_out), .alarm_out(sss_link_if_i.alarm_out));
   ////////////////////////////////////////
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   always @(posedge clk) begin
      cycles++;
      if (cycles == 10000) begin
         num_errors++;
         close_out();
      end
   end
   ////////////////////////////////////////
   task automatic close_out;
      $display("checks %0d errors %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   task automatic chkb(input string name, input logic exp, input logic got);
      samples_checked++;
      if (got !== exp) begin
         num_errors++;
         $display("[ERR] %s expected %b seen %b", name, exp, got);
      end
   endtask
   task automatic chkw(input string name, input logic [15:0] exp, input logic [15:0] got);
      samples_checked++;
      if (got !== exp) begin
         num_errors++;
         $display("[ERR] %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic step(input int n);
      repeat (n) @(negedge clk);
   endtask
   task automatic wait_code(input logic [4:0] c);
      for (int i = 0; i < 400 && status_code !== c; i++) @(negedge clk);
      chkw("status_code", {11'h0, c}, {11'h0, status_code});
   endtask
   task automatic wait_disp(input logic [2:0] d);
      for (int i = 0; i < 400 && disp_mode !== d; i++) @(negedge clk);
      chkw("disp_mode", {13'h0, d}, {13'h0, disp_mode});
   endtask
   ////////////////////////////////////////
   task automatic t_power;
      wait_code(`SSS_CODE_PWR_OFF);
      chkb("driver_ready_out", 1'b1, sss_link_if_i.driver_ready_out);
      chkw("tuning_select", 16'h0001, {14'h0, tuning_select});
      chkw("ratio", 16'h0258, load_inertia_ratio);
   endtask
   task automatic t_estimate;
      main_power = 1'b1;
      wait_code(`SSS_CODE_PWR_ON);
      wait_code(`SSS_CODE_EST_RDY);
      wait_disp(`SSS_DISP_BLINK);
      chkb("estimation_ready_out", 1'b1, sss_link_if_i.estimation_ready_out);
      chkb("windings_on", 1'b0, windings_on);
      chkw("monitor_data", 16'h0009, {8'h00, monitor_data});
      monitor_id = 8'h01;
      step(2);
      chkw("monitor_data", 16'h0000, {8'h00, monitor_data});
      run_req = 1'b1;
      wait_disp(`SSS_DISP_ROTATE);
      hi = 8'sh00;
      lo = 8'sh00;
      for (int i = 0; i < 80 && sss_link_if_i.setup_done_out !== 1'b1; i++) begin
         est_step_done = 1'b1;
         step(1);
         est_step_done = 1'b0;
         step(3);
         hi = (est_angle_deg > hi) ? est_angle_deg : hi;
         lo = (est_angle_deg < lo) ? est_angle_deg : lo;
      end
      chkw("angle_max", 16'h0012, {8'h00, hi});
      chkw("angle_min", 16'h00ee, {8'h00, lo});
      chkb("setup_done_out", 1'b1, sss_link_if_i.setup_done_out);
      wait_code(`SSS_CODE_SRV_RDY);
      wait_code(`SSS_CODE_SRV_ON);
      wait_disp(`SSS_DISP_ROTATE);
      chkb("windings_on", 1'b1, windings_on);
      chkb("cmd_enable_out", 1'b1, sss_link_if_i.cmd_enable_out);
      step(2);
      chkb("cmd_allowed", 1'b1, cmd_allowed);
   endtask
   task automatic t_travel;
      fwd_limit_in = 1'b1;
      wait_disp(`SSS_DISP_FWD_OT);
      rev_limit_in = 1'b1;
      step(8);
      wait_disp(`SSS_DISP_FWD_OT);
      fwd_limit_in = 1'b0;
      wait_disp(`SSS_DISP_REV_OT);
      rev_limit_in = 1'b0;
      regen_warn_in = 1'b1;
      wait_disp(`SSS_DISP_WARN_REGEN);
      chkb("warning_out", 1'b1, sss_link_if_i.warning_out);
      regen_warn_in = 1'b0;
      overload_warn_in = 1'b1;
      wait_disp(`SSS_DISP_WARN_OVL);
      overload_warn_in = 1'b0;
      wait_disp(`SSS_DISP_ROTATE);
      chkb("warning_out", 1'b0, sss_link_if_i.warning_out);
      emergency_stop_state = 1'b1;
      wait_code(`SSS_CODE_EMR);
      chkb("windings_on", 1'b0, windings_on);
      emergency_stop_state = 1'b0;
      wait_code(`SSS_CODE_SRV_ON);
   endtask
   task automatic t_alarm_soft;
      monitor_alarm = 1'b1;
      alarm_resettable = 1'b1;
      alarm_use_dbrake = 1'b1;
      alarm_cond = 1'b1;
      wait_disp(`SSS_DISP_ALARM);
      chkw("disp_alarm_code", 16'h003c, {8'h00, disp_alarm_code});
      chkb("dyn_brake", 1'b1, dyn_brake);
      chkb("cmd_enable_out", 1'b0, sss_link_if_i.cmd_enable_out);
      alarm_reset_req = 1'b1;
      for (int i = 0; i < RC + 20 && reset_timeout !== 1'b1; i++) step(1);
      chkb("reset_timeout", 1'b1, reset_timeout);
      chkb("alarm_out", 1'b1, sss_link_if_i.alarm_out);
      alarm_reset_req = 1'b0;
      step(4);
      alarm_cond = 1'b0;
      step(4);
      chkb("alarm_out", 1'b1, sss_link_if_i.alarm_out);
      alarm_reset_req = 1'b1;
      step(16);
      chkb("alarm_out", 1'b0, sss_link_if_i.alarm_out);
      chkb("driver_ready_out", 1'b1, sss_link_if_i.driver_ready_out);
      alarm_reset_req = 1'b0;
   endtask
   task automatic t_alarm_hard;
      monitor_alarm = 1'b0;
      alarm_resettable = 1'b0;
      alarm_use_dbrake = 1'b0;
      alarm_cond = 1'b1;
      wait_disp(`SSS_DISP_ALARM);
      chkb("zero_speed_cmd", 1'b1, zero_speed_cmd);
      chkb("dyn_brake", 1'b0, dyn_brake);
      alarm_cond = 1'b0;
      alarm_reset_req = 1'b1;
      step(RC + 20);
      alarm_reset_req = 1'b0;
      chkb("alarm_out", 1'b1, sss_link_if_i.alarm_out);
      run_req = 1'b0;
      srst = 1'b1;
      step(2);
      srst = 1'b0;
      wait_code(`SSS_CODE_EST_RDY);
      chkb("alarm_out", 1'b0, sss_link_if_i.alarm_out);
      chkb("setup_done_out", 1'b0, sss_link_if_i.setup_done_out);
   endtask
   ////////////////////////////////////////
   initial begin
      {main_power, emergency_stop_state, est_step_done, regen_warn_in, overload_warn_in} = 5'h00;
      {alarm_cond, alarm_resettable, alarm_use_dbrake, run_req, alarm_reset_req} = 5'h00;
      {monitor_alarm, fwd_limit_in, rev_limit_in, srst} = 4'h1;
      {alarm_code_in, monitor_id} = 16'h3c00;
      {load_inertia, rotor_inertia} = 32'h012c_0032;
      step(20);
      chkw("status_code", 16'h000f, {11'h0, status_code});
      srst = 1'b0;
      t_power;
      t_estimate;
      t_travel;
      t_alarm_soft;
      t_alarm_hard;
      close_out();
   end
endmodule
